//--- logic/itie_exec.sv
// Executor for port I/O, timer, interrupt-enable, stack, serial and bank instructions
`timescale 1ns/10ps

module itie_exec (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic [63:0]          PORT_IN,
  output logic [63:0]               PORT_OUT,
  input  wire logic [11:0]          TMR0_COUNT,
  input  wire logic [7:0]           TMR1_COUNT,
  output itie_pkg::itie_tmr_t       TMR_CTRL,
  output itie_pkg::itie_irq_t       IRQ_CTRL,
  input  wire logic [7:0]           SIO_IN,
  output logic [7:0]                SIO_DATA,
  output logic                      SIO_LOAD,
  output logic                      SIO_GO,
  output logic                      PC12,
  output logic                      MEM_BANK,
  output logic                      REG_BANK
);
  import itie_pkg::*;

  // ==========================================================
  // Decode helpers
  // Cycle count of an instruction from its first byte
  function automatic logic two_cycle(input logic [7:0] op);
    two_cycle = !(op == OPC_IDLE || op == OPC_ACCP || op == OPC_MEMP ||
                  op == OPC_BANK || op[7:2] == 6'b000010 ||
                  op[7:2] == 6'b001010);
  endfunction : two_cycle

  // Register hit test, used only by the error flag; the read mux decodes PADDR itself
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == OFS_INSTR) || (a == OFS_CORE) || (a == OFS_STAT) ||
               (a == OFS_MEM) || (a == OFS_TMR) || (a == OFS_SIO);
  endfunction : addr_hit

  // ==========================================================
  // State
  itie_state_t       st_q;          // Executor sequencing
  logic              left_q;        // Cycles still to run after this one
  logic [7:0]        b1_q;          // First instruction byte
  logic [7:0]        b2_q;          // Second instruction byte
  logic [3:0]        ac_q, ac_d;    // main_digit
  logic [3:0]        e_q, e_d;      // Auxiliary high digit
  logic [7:0]        hl_q, hl_d;    // pointer_pair
  logic [3:0]        dpl_q, dpl_d;  // port_select_low_digit
  logic [7:0]        sp_q, sp_d;    // stack_pointer
  logic              zf_q, zf_d;    // zero_flag
  logic [15:0][3:0]  port_q;        // Output port latches
  logic [15:0][3:0]  port_d;
  itie_tmr_t         tmr_q, tmr_d;  // Timer control image
  itie_irq_t         irq_q, irq_d;  // Interrupt gate and enables
  logic [7:0]        sio_q, sio_d;  // serial_shift_register image
  logic              sld_d, sgo_d;  // Serial strobes next value
  logic              sld_q, sgo_q;
  logic              pc12_q, pc12_d;
  logic              btmp_q, btmp_d;   // Bank switch pending for one op
  logic              mbank_q;          // Effective memory bank
  logic [7:0]        pcl_q, pcl_d;     // Branch target low byte
  logic              taken_q, taken_d; // Last bit-test outcome
  logic [3:0]        mem [0:255];      // Data memory nibbles
  logic              mwe_a, mwe_b;     // Memory write strobes
  logic [3:0]        mwd_a, mwd_b;     // Memory write data
  logic [7:0]        hl_nx;            // Second nibble of a memory byte

  // ==========================================================
  // Bus qualification
  logic        access;     // Access phase not yet answered
  logic        instr_wr;   // Issue write seen in access phase
  logic        take;       // Access answered at this edge
  logic        do_exec;    // Last cycle of running instruction
  logic        core_wr;
  logic        mem_wr;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [31:0] rd_mux;

  assign access   = PSEL && PENABLE && !pready_q;
  assign instr_wr = access && PWRITE && (PADDR == OFS_INSTR);
  // An issue write waits while an instruction is still running
  assign take     = access && !(instr_wr && st_q != ST_IDLE);
  assign core_wr  = take && PWRITE && (PADDR == OFS_CORE);
  assign mem_wr   = take && PWRITE && (PADDR == OFS_MEM);
  assign do_exec  = (st_q == ST_RUN) && !left_q;
  assign hl_nx    = hl_q + 8'h01;

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      OFS_CORE: rd_mux = {3'h0, zf_q, sp_q, dpl_q, hl_q, e_q, ac_q};
      OFS_STAT: rd_mux = {8'h00, irq_q.lower, irq_q.upper, pcl_q,
                          1'b0, taken_q, btmp_q, pc12_q,
                          tmr_q.run1, tmr_q.run0, irq_q.gate,
                          st_q != ST_IDLE};
      OFS_MEM:  rd_mux = {28'h0000000, mem[hl_q]};
      OFS_TMR:  rd_mux = {12'h000, tmr_q.reload1, tmr_q.reload0};
      OFS_SIO:  rd_mux = {24'h000000, sio_q};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Bus answer: registered, one wait state, error on unmapped
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (CE) begin
      pready_q  <= take;
      pslverr_q <= take && !addr_hit(PADDR);
      if (take && !PWRITE) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Sequencer: both bytes are latched before any effect
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_q   <= ST_IDLE;
      left_q <= 1'b0;
      b1_q   <= 8'h00;
      b2_q   <= 8'h00;
    end else if (CE) begin
      unique case (st_q)
        ST_IDLE: begin
          if (take && instr_wr) begin
            b1_q   <= PWDATA[7:0];
            b2_q   <= PWDATA[15:8];
            left_q <= two_cycle(PWDATA[7:0]);
            st_q   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (left_q) begin
            left_q <= 1'b0;
          end else begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Port value for bit tests; controls replace pins after bank switch
  logic [3:0] tst_src;
  always_comb begin
    tst_src = PORT_IN[dpl_q*4 +: 4];
    if (btmp_q) begin
      // Only readable controls answer; others read as zero
      unique case (dpl_q)
        4'h0:    tst_src = irq_q.upper;
        4'h1:    tst_src = irq_q.lower;
        4'h2:    tst_src = {irq_q.gate, tmr_q.run1, tmr_q.run0, pc12_q};
        default: tst_src = 4'h0;
      endcase
    end
  end

  // ==========================================================
  // Instruction effects
  always_comb begin
    ac_d    = ac_q;
    e_d     = e_q;
    hl_d    = hl_q;
    dpl_d   = dpl_q;
    sp_d    = sp_q;
    zf_d    = zf_q;
    port_d  = port_q;
    tmr_d   = tmr_q;
    irq_d   = irq_q;
    sio_d   = sio_q;
    sld_d   = 1'b0;
    sgo_d   = 1'b0;
    pc12_d  = pc12_q;
    btmp_d  = btmp_q;
    pcl_d   = pcl_q;
    taken_d = taken_q;
    mwe_a   = 1'b0;
    mwe_b   = 1'b0;
    mwd_a   = 4'h0;
    mwd_b   = 4'h0;
    if (do_exec) begin
      // A bank switch covers just the instruction after it
      btmp_d = 1'b0;
      casez (b1_q)
        OPC_IDLE: begin
          // Only a pending bank switch is dropped; the cycle is consumed
        end
        OPC_ACCP: port_d[dpl_q] = ac_q;
        OPC_MEMP: port_d[dpl_q] = mem[hl_q];
        OPC_BSET: port_d[dpl_q][b1_q[1:0]] = 1'b1;
        OPC_BCLR: begin
          port_d[dpl_q][b1_q[1:0]] = 1'b0;
          zf_d = (port_d[dpl_q] == 4'h0);
        end
        OPC_LDT0: tmr_d.reload0 = {mem[hl_q], mem[hl_nx], ac_q};
        OPC_RDT0: begin
          mwe_a = 1'b1;
          mwd_a = TMR0_COUNT[11:8];
          mwe_b = 1'b1;
          mwd_b = TMR0_COUNT[7:4];
          ac_d  = TMR0_COUNT[3:0];
        end
        OPC_BANK: btmp_d = 1'b1;
        OPC_DRD: begin
          ac_d = PORT_IN[b2_q[3:0]*4 +: 4];
          zf_d = (PORT_IN[b2_q[3:0]*4 +: 4] == 4'h0);
        end
        OPC_DWR: port_d[b2_q[3:0]] = ac_q;
        OPC_PAND: begin
          port_d[b2_q[3:0]] = PORT_IN[b2_q[3:0]*4 +: 4] & b2_q[7:4];
          zf_d = (port_d[b2_q[3:0]] == 4'h0);
        end
        OPC_POR: begin
          port_d[b2_q[3:0]] = PORT_IN[b2_q[3:0]*4 +: 4] | b2_q[7:4];
          zf_d = (port_d[b2_q[3:0]] == 4'h0);
        end
        OPC_BTST, OPC_BNTST: begin
          // Branch sense is bit 6 of the opcode
          taken_d = (tst_src[b1_q[1:0]] == b1_q[6]);
          if (taken_d) begin
            pcl_d = b2_q;
          end
        end
        OPC_IMM: begin
          unique case (b2_q[7:4])
            SUB_EIH: irq_d.upper = irq_q.upper | b2_q[3:0];
            SUB_EIL: irq_d.lower = irq_q.lower | b2_q[3:0];
            SUB_DIH: begin
              irq_d.upper = irq_q.upper & ~b2_q[3:0];
              zf_d = (irq_d.upper == 4'h0);
            end
            SUB_DIL: begin
              irq_d.lower = irq_q.lower & ~b2_q[3:0];
              zf_d = (irq_d.lower == 4'h0);
            end
            SUB_SB:  pc12_d = b2_q[0];
            default: begin
              // Unused sub-codes act as idle
            end
          endcase
        end
        OPC_EXT: begin
          unique case (b2_q)
            X_READ_PORTS_FOUR_FIVE: begin
              e_d  = PORT_IN[PORT_HI*4 +: 4];
              ac_d = PORT_IN[PORT_LO*4 +: 4];
            end
            X_WRITE_PORTS_FOUR_FIVE: begin
              port_d[PORT_HI] = e_q;
              port_d[PORT_LO] = ac_q;
            end
            X_LDT1: tmr_d.reload1 = {e_q, ac_q};
            X_RDT1: {e_d, ac_d} = TMR1_COUNT;
            X_RUN0: tmr_d.run0 = 1'b1;
            X_RUN1: tmr_d.run1 = 1'b1;
            X_HLT0: tmr_d.run0 = 1'b0;
            X_HLT1: tmr_d.run1 = 1'b0;
            X_GON:  irq_d.gate = 1'b1;
            X_GOFF: irq_d.gate = 1'b0;
            X_LDSP: sp_d = {e_q, ac_q};
            X_RDSP: {e_d, ac_d} = sp_q;
            X_SGO:  sgo_d = 1'b1;
            X_SLD: begin
              sio_d = {e_q, ac_q};
              sld_d = 1'b1;
            end
            X_SRD:  {e_d, ac_d} = SIO_IN;
            default: begin
              // Standby and unused codes act as idle
            end
          endcase
        end
        default: begin
          // Opcodes outside this group only drop a pending bank switch
        end
      endcase
    end else if (core_wr) begin
      // Software seeds the digits in any cycle but an instruction's last, where the write is lost
      ac_d  = PWDATA[CORE_AC +: 4];
      e_d   = PWDATA[CORE_E +: 4];
      hl_d  = PWDATA[CORE_HL +: 8];
      dpl_d = PWDATA[CORE_DPL +: 4];
      sp_d  = PWDATA[CORE_SP +: 8];
      zf_d  = PWDATA[CORE_ZF];
    end
  end

  // ==========================================================
  // Core digits and flags
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ac_q  <= 4'h0;
      e_q   <= 4'h0;
      hl_q  <= 8'h00;
      dpl_q <= 4'h0;
      sp_q  <= RST_SP;
      zf_q  <= 1'b0;
    end else if (CE) begin
      ac_q  <= ac_d;
      e_q   <= e_d;
      hl_q  <= hl_d;
      dpl_q <= dpl_d;
      sp_q  <= sp_d;
      zf_q  <= zf_d;
    end
  end

  // Port latches
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      port_q <= {16{RST_PORT}};
    end else if (CE) begin
      port_q <= port_d;
    end
  end

  // Timer, interrupt and serial controls
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tmr_q <= '0;
      irq_q <= '0;
      sio_q <= 8'h00;
      sld_q <= 1'b0;
      sgo_q <= 1'b0;
    end else if (CE) begin
      tmr_q <= tmr_d;
      irq_q <= irq_d;
      sio_q <= sio_d;
      sld_q <= sld_d;
      sgo_q <= sgo_d;
    end
  end

  // Bank and branch state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pc12_q  <= 1'b0;
      btmp_q  <= 1'b0;
      mbank_q <= 1'b0;
      pcl_q   <= 8'h00;
      taken_q <= 1'b0;
    end else if (CE) begin
      pc12_q  <= pc12_d;
      btmp_q  <= btmp_d;
      // Pending switch flips the bank seen by the next fetch
      mbank_q <= pc12_d ^ btmp_d;
      pcl_q   <= pcl_d;
      taken_q <= taken_d;
    end
  end

  // ==========================================================
  // Data memory; no reset, contents are software data
  always_ff @(posedge CLK_SYS) begin
    if (CE) begin
      if (mwe_a) begin
        mem[hl_q] <= mwd_a;
      end
      if (mwe_b) begin
        mem[hl_nx] <= mwd_b;
      end
      if (mem_wr) begin
        mem[PWDATA[7:0]] <= PWDATA[MEM_DAT +: 4];
      end
    end
  end

  // ==========================================================
  // Outputs, all taken from flip-flops
  assign PRDATA   = prdata_q;
  assign PREADY   = pready_q;
  assign PSLVERR  = pslverr_q;
  assign PORT_OUT = port_q;
  assign TMR_CTRL = tmr_q;
  assign IRQ_CTRL = irq_q;
  assign SIO_DATA = sio_q;
  assign SIO_LOAD = sld_q;
  assign SIO_GO   = sgo_q;
  assign PC12     = pc12_q;
  assign MEM_BANK = mbank_q;
  assign REG_BANK = btmp_q;

endmodule : itie_exec

//--- pkg/itie_pkg.sv
// Constants, types and encodings shared by the I/O, timer and interrupt executor
package itie_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] OFS_INSTR = 8'h00;  // Instruction issue, write only
  localparam logic [7:0] OFS_CORE  = 8'h04;  // Core digits and pointers
  localparam logic [7:0] OFS_STAT  = 8'h08;  // Status, read only
  localparam logic [7:0] OFS_MEM   = 8'h0C;  // Data memory nibble access
  localparam logic [7:0] OFS_TMR   = 8'h10;  // Timer reload values, read only
  localparam logic [7:0] OFS_SIO   = 8'h14;  // Serial shift image, read only

  // ==========================================================
  // Field positions
  localparam int CORE_AC  = 0;   // Main digit [3:0]
  localparam int CORE_E   = 4;   // Auxiliary digit [7:4]
  localparam int CORE_HL  = 8;   // Pointer pair [15:8]
  localparam int CORE_DPL = 16;  // Port select digit [19:16]
  localparam int CORE_SP  = 20;  // Stack pointer [27:20]
  localparam int CORE_ZF  = 28;  // Zero flag
  localparam int MEM_DAT  = 8;   // Memory write data [11:8]
  localparam int STAT_PCL = 8;   // Branch target byte [15:8]
  localparam int STAT_UP  = 16;  // Upper enable group [19:16]
  localparam int STAT_LO  = 20;  // Lower enable group [23:20]
  localparam int TMR_R1   = 12;  // Timer one reload [19:12]

  // ==========================================================
  // Single-byte and first-byte opcodes
  localparam logic [7:0] OPC_IDLE  = 8'h00;         // idle_instruction
  localparam logic [7:0] OPC_ACCP  = 8'h25;         // acc_to_port
  localparam logic [7:0] OPC_MEMP  = 8'h1A;         // mem_to_port
  localparam logic [7:0] OPC_BSET  = 8'b0000_10??;  // port_bit_set
  localparam logic [7:0] OPC_BCLR  = 8'b0010_10??;  // port_bit_clear
  localparam logic [7:0] OPC_LDT0  = 8'hCA;         // load_timer_zero_reload
  localparam logic [7:0] OPC_RDT0  = 8'hCB;         // read_timer_zero_count
  localparam logic [7:0] OPC_BANK  = 8'h1B;         // Temporary bank switch
  localparam logic [7:0] OPC_DRD   = 8'hC6;         // direct_port_read
  localparam logic [7:0] OPC_DWR   = 8'hC7;         // direct_port_write
  localparam logic [7:0] OPC_PAND  = 8'hC5;         // port_and_immediate
  localparam logic [7:0] OPC_POR   = 8'hC4;         // port_or_immediate
  localparam logic [7:0] OPC_IMM   = 8'hCE;         // Prefix: sub-op plus immediate
  localparam logic [7:0] OPC_EXT   = 8'hCF;         // Prefix: extended operations
  localparam logic [7:0] OPC_BTST  = 8'b1101_10??;  // Branch on port bit one
  localparam logic [7:0] OPC_BNTST = 8'b1001_10??;  // Branch on port bit zero

  // ==========================================================
  // Second-byte codes after the prefixes
  localparam logic [3:0] SUB_EIH = 4'h0;  // upper_irq_group_enable
  localparam logic [3:0] SUB_EIL = 4'h1;  // lower_irq_group_enable
  localparam logic [3:0] SUB_DIH = 4'h2;  // upper_irq_group_disable
  localparam logic [3:0] SUB_DIL = 4'h3;  // lower_irq_group_disable
  localparam logic [3:0] SUB_SB  = 4'h4;  // select_mem_bank
  localparam logic [7:0] X_READ_PORTS_FOUR_FIVE  = 8'h01; // read_ports_four_five
  localparam logic [7:0] X_WRITE_PORTS_FOUR_FIVE  = 8'h02; // write_ports_four_five
  localparam logic [7:0] X_LDT1  = 8'h03; // load_timer_one_reload
  localparam logic [7:0] X_RDT1  = 8'h04; // read_timer_one_count
  localparam logic [7:0] X_RUN0  = 8'h05; // run_timer_zero
  localparam logic [7:0] X_RUN1  = 8'h06; // run_timer_one
  localparam logic [7:0] X_HLT0  = 8'h07; // halt_timer_counter, timer zero
  localparam logic [7:0] X_HLT1  = 8'h08; // halt_timer_counter, timer one
  localparam logic [7:0] X_GON   = 8'h09; // global_irq_gate_on
  localparam logic [7:0] X_GOFF  = 8'h0A; // global_irq_gate_off
  localparam logic [7:0] X_LDSP  = 8'h0B; // load_stack_pointer
  localparam logic [7:0] X_RDSP  = 8'h0C; // Stack pointer to digits
  localparam logic [7:0] X_SGO   = 8'h0D; // serial_transfer_go
  localparam logic [7:0] X_SLD   = 8'h0E; // serial_shift_load
  localparam logic [7:0] X_SRD   = 8'h0F; // serial_shift_fetch

  // ==========================================================
  // Fixed port numbers and reset values
  localparam logic [3:0] PORT_HI  = 4'h4;   // Port paired with auxiliary digit
  localparam logic [3:0] PORT_LO  = 4'h5;   // Port paired with main digit
  localparam logic [7:0] RST_SP   = 8'h00;  // Stack pointer after reset
  localparam logic [3:0] RST_PORT = 4'hF;   // Port latches idle high

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} itie_state_t;

  typedef struct packed {
    logic        run0;     // Timer zero counter running
    logic        run1;     // Timer one counter running
    logic [11:0] reload0;  // Timer zero reload value
    logic [7:0]  reload1;  // Timer one reload register A
  } itie_tmr_t;

  typedef struct packed {
    logic       gate;   // global_irq_gate
    logic [3:0] upper;  // upper_irq_mask_reg
    logic [3:0] lower;  // lower_irq_mask_reg
  } itie_irq_t;

endpackage : itie_pkg

//--- verification/itie_exec_monitor.sv
// Port-level checker for the I/O, timer and interrupt executor
`timescale 1ns/10ps
// =====================================================
// Checker
module itie_exec_monitor (
  input wire logic                CLK_SYS,
  input wire logic                RESET,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  input wire logic [63:0]         PORT_OUT,
  input wire itie_pkg::itie_tmr_t TMR_CTRL,
  input wire itie_pkg::itie_irq_t IRQ_CTRL,
  input wire logic [7:0]          SIO_DATA,
  input wire logic                SIO_LOAD,
  input wire logic                SIO_GO,
  input wire logic                PC12
);
  import itie_pkg::*;
  // Single clock domain, so one default clocking and reset
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("bus answer held past one cycle");
  chk_ready_cause: assert property ($rose(PREADY) |-> $past(PSEL && PENABLE))
    else $error("bus answer without access phase");
  chk_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag without answer");
  // Ports move only one or two cycles after an accepted instruction
  chk_port_cause: assert property ($changed(PORT_OUT) |-> $past(PREADY) || $past(PREADY, 2))
    else $error("port latch changed with no instruction");
  chk_timer_cause: assert property ($changed(TMR_CTRL) |-> $past(PREADY, 2))
    else $error("timer control changed off the two-cycle slot");
  chk_irq_cause: assert property ($changed(IRQ_CTRL) |-> $past(PREADY, 2))
    else $error("interrupt control changed off the two-cycle slot");
  chk_bank_cause: assert property ($changed(PC12) |-> $past(PREADY, 2))
    else $error("bank bit changed off the two-cycle slot");
  chk_serial_go_pulse: assert property (SIO_GO |=> !SIO_GO)
    else $error("serial start longer than one cycle");
  chk_serial_image: assert property ($changed(SIO_DATA) |-> SIO_LOAD)
    else $error("serial image changed without load pulse");
  cover property (SIO_GO);
  cover property (PSLVERR);
  cover property ($rose(PC12));
endmodule : itie_exec_monitor

bind itie_exec itie_exec_monitor u_itie_exec_monitor (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_OUT(PORT_OUT), .TMR_CTRL(TMR_CTRL),
  .IRQ_CTRL(IRQ_CTRL), .SIO_DATA(SIO_DATA), .SIO_LOAD(SIO_LOAD), .SIO_GO(SIO_GO), .PC12(PC12));

//--- verification/test_itie_exec.sv
// Self-checking bench for the I/O, timer and interrupt executor
`timescale 1ns/10ps
// =====================================================
// Bench
module test_itie_exec;
  import itie_pkg::*;
  logic        CLK_SYS = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, err;
  logic [7:0]  PADDR = 8'h00, SIO_DATA;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [63:0] PORT_OUT;
  logic        PREADY, PSLVERR, SIO_LOAD, SIO_GO, PC12, MEM_BANK, REG_BANK;
  itie_tmr_t   TMR_CTRL;
  itie_irq_t   IRQ_CTRL;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  logic        go_seen = 1'b0, ld_seen = 1'b0;
  always #10 CLK_SYS = ~CLK_SYS;
  // Serial strobes last one cycle, so latch that each was seen
  always @(posedge CLK_SYS) begin
    if (SIO_GO === 1'b1) go_seen <= 1'b1;
    if (SIO_LOAD === 1'b1) ld_seen <= 1'b1;
  end
  // Pin pattern puts value 15-n on port n, so port 15 reads zero
  itie_exec u_itie_exec (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PORT_IN(64'h0123456789ABCDEF), .PORT_OUT(PORT_OUT), .TMR0_COUNT(12'h7E1), .TMR1_COUNT(8'h5A),
    .TMR_CTRL(TMR_CTRL), .IRQ_CTRL(IRQ_CTRL), .SIO_IN(8'hC3), .SIO_DATA(SIO_DATA), .SIO_LOAD(SIO_LOAD),
    .SIO_GO(SIO_GO), .PC12(PC12), .MEM_BANK(MEM_BANK), .REG_BANK(REG_BANK));
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; waits for the answer rather than assuming its latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask : apb
  // Issue an instruction, then let both execute cycles land
  task ex(input logic [15:0] i);
    apb(1'b1, OFS_INSTR, {16'h0000, i});
    repeat (2) @(posedge CLK_SYS);
  endtask : ex
  task pt(input int n, input logic [3:0] e);
    chk("port", 32'(e), 32'(PORT_OUT[4*n +: 4]));
  endtask : pt
  task core(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, OFS_CORE, 32'h0);
    chk("core", e, rd & m);
  endtask : core
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RESET <= 1'b0;
    apb(1'b1, OFS_CORE, 32'h0002_103A);
    ex(16'h0025); pt(2, 4'hA);
    ex(16'h07C7); pt(7, 4'hA);
    ex(16'h02CF); pt(4, 4'h3); pt(5, 4'hA);
    ex(16'h0029); pt(2, 4'h8);
    ex(16'h000A); pt(2, 4'hC);
    ex(16'h0000); pt(2, 4'hC);
    ex(16'hC9C5); pt(9, 4'h4);
    ex(16'h8AC4); pt(10, 4'hD);
    apb(1'b1, OFS_MEM, 32'h0000_0610);
    apb(1'b1, OFS_MEM, 32'h0000_0911);
    ex(16'h001A); pt(2, 4'h6);
    ex(16'h00CA); chk("reload0", 32'h69A, 32'(TMR_CTRL.reload0));
    ex(16'h00CB); ex(16'h00CA); chk("reload0", 32'h7E1, 32'(TMR_CTRL.reload0));
    $display("port tests done");
    ex(16'h0FC6); core(32'h1000_000F, 32'h1000_0000);
    ex(16'h01CF); core(32'h0000_00FF, 32'h0000_00BA);
    ex(16'h03CF); chk("reload1", 32'hBA, 32'(TMR_CTRL.reload1));
    ex(16'h04CF); core(32'h0000_00FF, 32'h0000_005A);
    ex(16'h05CF); ex(16'h06CF); ex(16'h07CF); chk("run", 32'h1, 32'({TMR_CTRL.run0, TMR_CTRL.run1}));
    ex(16'h0BCF); core(32'h0FF0_0000, 32'h05A0_0000);
    ex(16'h0ECF); chk("sio", 32'h5A, 32'(SIO_DATA)); chk("go", 32'h0, 32'(go_seen));
    ex(16'h0DCF); ex(16'h0FCF); core(32'h0000_00FF, 32'h0000_00C3);
    chk("go", 32'h1, 32'(go_seen)); chk("load", 32'h1, 32'(ld_seen));
    $display("timer and serial tests done");
    ex(16'h05CE); ex(16'h13CE); ex(16'h24CE); ex(16'h09CF); chk("irq", 32'h113, 32'(IRQ_CTRL));
    core(32'h1000_0000, 32'h0000_0000);
    ex(16'h0ACF); chk("irq", 32'h013, 32'(IRQ_CTRL));
    ex(16'h41CE); chk("pc12", 32'h1, 32'(PC12));
    ex(16'h001B); chk("membank", 32'h0, 32'(MEM_BANK)); chk("regbank", 32'h1, 32'(REG_BANK));
    // Bit 3 of port 2 pins is one but the gate control is zero, so only the switch branches
    ex(16'h779B); apb(1'b0, OFS_STAT, 32'h0); chk("test", 32'h7740, rd & 32'hFF40);
    chk("membank", 32'h1, 32'(MEM_BANK)); chk("regbank", 32'h0, 32'(REG_BANK));
    apb(1'b0, 8'h20, 32'h0); chk("slverr", 32'h1, 32'(err));
    $display("control tests done");
    test_done;
  end
endmodule : test_itie_exec
